// >>> shared/ids_pkg.sv
// shared constants and types for the two-wire converter link
package ids_pkg;
	// clock and link timing
	localparam int CLK_PERIOD_NS = 5;
	localparam int SCL_PERIOD_NS = 2500;
	localparam int QTR_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
	// slave address: fixed upper six bits, low bit from the select pin
	localparam logic [5:0] ADDR_PREFIX = 6'h26;
	localparam logic [6:0] TARGET_RST = 7'h4C;
	// control byte fields
	localparam int PD_FLAG_BIT = 0;
	localparam int RD_SRC_BIT = 1;
	localparam logic [7:0] CTRL_ZERO_MASK = 8'hCA;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [15:0] DAC_RST = 16'h0000;
	localparam logic [7:0] CTRL_RST = 8'h00;
	// controller register byte offsets
	localparam logic [4:0] REG_TARGET = 5'h00;
	localparam logic [4:0] REG_TXDATA = 5'h04;
	localparam logic [4:0] REG_CMD = 5'h08;
	localparam logic [4:0] REG_STATUS = 5'h0C;
	localparam logic [4:0] REG_RXDATA = 5'h10;
	localparam int CMD_WRITE_BIT = 0;
	localparam int CMD_READ_BIT = 1;
	localparam int CMD_REPEAT_BIT = 2;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_NACK_BIT = 1;
	// byte position within a transaction
	typedef enum logic [1:0] {
		BY_ADDR = 2'b00,
		BY_CTRL = 2'b01,
		BY_HIGH = 2'b10,
		BY_LOW = 2'b11
	} ids_byte_t;
	typedef enum logic [2:0] {
		DS_IDLE = 3'b000,
		DS_RX = 3'b001,
		DS_RX_ACK = 3'b010,
		DS_TX = 3'b011,
		DS_TX_ACK = 3'b100
	} ids_dev_state_t;
	typedef enum logic [1:0] {
		MS_IDLE = 2'b00,
		MS_START = 2'b01,
		MS_BIT = 2'b10,
		MS_STOP = 2'b11
	} ids_mst_state_t;
endpackage : ids_pkg

// >>> shared/ids_link_if.sv
// open-drain two-wire link joining controller and converter
`timescale 1ns/1ps
interface ids_link_if;
	logic scl_o;
	logic scl_oe;
	logic sda_m_o;
	logic sda_m_oe;
	logic sda_s_o;
	logic sda_s_oe;
	logic scl;
	logic sda;
	// wired-and with pull-up: low while any enabled driver pulls low
	assign scl = !(scl_oe && !scl_o);
	assign sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));
	modport master (output scl_o, output scl_oe, output sda_m_o,
		output sda_m_oe, input scl, input sda);
	modport device (output sda_s_o, output sda_s_oe, input scl,
		input sda);
endinterface : ids_link_if

// >>> hw/ids_device.sv
// converter end: serial slave sequencer with conversion registers
//
// The implementer's own choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
module ids_device
	import ids_pkg::*;
(
	input wire logic clk, // 200 MHz system clock
	input wire logic resetn, // async reset, active low
	ids_link_if.device link, // two-wire bus
	input wire logic address_select_pin, // address low bit strap pin
	input wire logic read_holding, // read returns holding register
	output logic [15:0] dac_word_ff, // active conversion word
	output logic dac_update_ff, // one-cycle pulse on update
	output logic power_down_ff, // power-down active
	output logic [2:0] shutdown_mode_ff, // selected shutdown mode
	output logic [7:0] ctrl_ff // last control byte received
);
	typedef struct packed {
		logic scl_s1;
		logic scl_s2;
		logic scl_d;
		logic sda_s1;
		logic sda_s2;
		logic sda_d;
		logic sel_s1;
		logic sel_s2;
		ids_dev_state_t st;
		ids_byte_t by;
		logic [3:0] bitcnt;
		logic [7:0] shift;
		logic rw;
		logic [1:0] rd_idx;
		logic mack;
		logic pend_upd;
		logic sda_oe;
		logic [15:0] hold;
		logic [15:0] dac;
		logic upd;
		logic pd;
		logic [2:0] pdmode;
		logic [7:0] ctrl;
	} ids_dev_st_t;

	ids_dev_st_t r_ff;
	ids_dev_st_t nxt_r;
	logic scl_rise;
	logic scl_fall;
	logic start_ev;
	logic stop_ev;
	logic [15:0] rd_word;
	logic [7:0] rd_ctrl;

	// bus events seen through the synchronised lines
	assign scl_rise = r_ff.scl_s2 && !r_ff.scl_d;
	assign scl_fall = !r_ff.scl_s2 && r_ff.scl_d;
	assign start_ev = r_ff.scl_s2 && r_ff.scl_d && r_ff.sda_d
		&& !r_ff.sda_s2;
	assign stop_ev = r_ff.scl_s2 && r_ff.scl_d && !r_ff.sda_d
		&& r_ff.sda_s2;
	// read-back source and the control byte that reports it
	assign rd_word = read_holding ? r_ff.hold : r_ff.dac;
	assign rd_ctrl = {r_ff.ctrl[7:2], read_holding,
		r_ff.ctrl[PD_FLAG_BIT]};

	// next-state logic of the sequencer
	always_comb begin
		nxt_r = r_ff;
		nxt_r.scl_s1 = link.scl;
		nxt_r.scl_s2 = r_ff.scl_s1;
		nxt_r.scl_d = r_ff.scl_s2;
		nxt_r.sda_s1 = link.sda;
		nxt_r.sda_s2 = r_ff.sda_s1;
		nxt_r.sda_d = r_ff.sda_s2;
		nxt_r.sel_s1 = address_select_pin;
		nxt_r.sel_s2 = r_ff.sel_s1;
		nxt_r.upd = 1'b0;
		if (start_ev) begin
			// start or repeated start: back to address phase
			nxt_r.st = DS_RX;
			nxt_r.by = BY_ADDR;
			nxt_r.bitcnt = 4'h0;
			nxt_r.sda_oe = 1'b0;
		end else if (stop_ev) begin
			// data line released; conversion outputs and held values are left as they stand
			nxt_r.st = DS_IDLE;
			nxt_r.sda_oe = 1'b0;
		end else begin
			case (r_ff.st)
				DS_IDLE: begin
					nxt_r.sda_oe = 1'b0;
				end
				DS_RX: begin
					if (scl_rise) begin
						// sample while clock high, msb first
						nxt_r.shift = {r_ff.shift[6:0], r_ff.sda_s2};
						nxt_r.bitcnt = r_ff.bitcnt + 4'h1;
					end else if (scl_fall && r_ff.bitcnt == BITS_PER_BYTE) begin
						nxt_r.st = DS_RX_ACK;
						nxt_r.sda_oe = 1'b1;
						case (r_ff.by)
							BY_ADDR: begin
								if (r_ff.shift[7:1] != {ADDR_PREFIX, r_ff.sel_s2}) begin
									nxt_r.st = DS_IDLE;
									nxt_r.sda_oe = 1'b0;
								end
								nxt_r.rw = r_ff.shift[0];
							end
							BY_CTRL: begin
								nxt_r.ctrl = r_ff.shift & ~CTRL_ZERO_MASK;
							end
							BY_HIGH: begin
								nxt_r.hold[15:8] = r_ff.shift;
							end
							BY_LOW: begin
								nxt_r.hold[7:0] = r_ff.shift;
								nxt_r.pend_upd = 1'b1;
							end
							default: begin
								nxt_r.st = DS_IDLE;
							end
						endcase
					end
				end
				DS_RX_ACK: begin
					if (scl_fall) begin
						nxt_r.sda_oe = 1'b0;
						nxt_r.bitcnt = 4'h0;
						nxt_r.pend_upd = 1'b0;
						if (r_ff.pend_upd) begin
							// update on the fall that ends the acknowledge
							if (r_ff.ctrl[PD_FLAG_BIT]) begin
								nxt_r.pd = 1'b1;
								nxt_r.pdmode = r_ff.hold[15:13];
							end else begin
								nxt_r.pd = 1'b0;
								nxt_r.dac = r_ff.hold;
								nxt_r.upd = 1'b1;
							end
						end
						case (r_ff.by)
							BY_ADDR: begin
								if (r_ff.rw) begin
									// first read byte goes out at once
									nxt_r.st = DS_TX;
									nxt_r.rd_idx = 2'h0;
									nxt_r.shift = rd_word[15:8];
									nxt_r.sda_oe = !rd_word[15];
								end else begin
									nxt_r.st = DS_RX;
									nxt_r.by = BY_CTRL;
								end
							end
							BY_CTRL: begin
								nxt_r.st = DS_RX;
								nxt_r.by = BY_HIGH;
							end
							BY_HIGH: begin
								nxt_r.st = DS_RX;
								nxt_r.by = BY_LOW;
							end
							default: begin
								nxt_r.st = DS_RX;
								nxt_r.by = BY_HIGH;
							end
						endcase
					end
				end
				DS_TX: begin
					if (scl_fall) begin
						// new bit only after the clock has fallen
						if (r_ff.bitcnt == BITS_PER_BYTE - 4'h1) begin
							nxt_r.sda_oe = 1'b0;
							nxt_r.st = DS_TX_ACK;
						end else begin
							nxt_r.shift = {r_ff.shift[6:0], 1'b0};
							nxt_r.sda_oe = !r_ff.shift[6];
							nxt_r.bitcnt = r_ff.bitcnt + 4'h1;
						end
					end
				end
				DS_TX_ACK: begin
					if (scl_rise) begin
						nxt_r.mack = !r_ff.sda_s2;
					end else if (scl_fall) begin
						nxt_r.bitcnt = 4'h0;
						if (r_ff.mack && r_ff.rd_idx != 2'h2) begin
							nxt_r.st = DS_TX;
							nxt_r.rd_idx = r_ff.rd_idx + 2'h1;
							if (r_ff.rd_idx == 2'h0) begin
								nxt_r.shift = rd_word[7:0];
								nxt_r.sda_oe = !rd_word[7];
							end else begin
								nxt_r.shift = rd_ctrl;
								nxt_r.sda_oe = !rd_ctrl[7];
							end
						end else begin
							// not-acknowledge ends the read
							nxt_r.st = DS_IDLE;
						end
					end
				end
				default: begin
					nxt_r.st = DS_IDLE;
					nxt_r.sda_oe = 1'b0;
				end
			endcase
		end
	end

	// state register
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			r_ff <= '{scl_s1: 1'b1, scl_s2: 1'b1, scl_d: 1'b1,
				sda_s1: 1'b1, sda_s2: 1'b1, sda_d: 1'b1,
				sel_s1: 1'b0, sel_s2: 1'b0, st: DS_IDLE, by: BY_ADDR,
				bitcnt: 4'h0, shift: 8'h00, rw: 1'b0, rd_idx: 2'h0,
				mack: 1'b0, pend_upd: 1'b0, sda_oe: 1'b0,
				hold: DAC_RST, dac: DAC_RST, upd: 1'b0, pd: 1'b0,
				pdmode: 3'h0, ctrl: CTRL_RST};
		end else begin
			r_ff <= nxt_r;
		end
	end

	// outputs straight from the state register
	assign link.sda_s_o = 1'b0;
	assign link.sda_s_oe = r_ff.sda_oe;
	assign dac_word_ff = r_ff.dac;
	assign dac_update_ff = r_ff.upd;
	assign power_down_ff = r_ff.pd;
	assign shutdown_mode_ff = r_ff.pdmode;
	assign ctrl_ff = r_ff.ctrl;
endmodule : ids_device

// >>> hw/ids_master.sv
// controller end: bus master driven from avalon registers
`timescale 1ns/1ps
module ids_master
	import ids_pkg::*;
#(
	parameter int QTR = QTR_CYC // clocks per quarter of a bit
) (
	input wire logic clk, // 200 MHz system clock
	input wire logic resetn, // async reset, active low
	ids_link_if.master link, // two-wire bus
	input wire logic [4:0] avs_address, // byte address
	input wire logic avs_read, // read request
	input wire logic avs_write, // write request
	input wire logic [31:0] avs_writedata, // write data
	input wire logic [3:0] avs_byteenable, // byte lanes
	output logic [31:0] avs_readdata, // read data
	output logic avs_waitrequest // stall, high until answer
);
	typedef struct packed {
		logic sda_s1;
		logic sda_s2;
		ids_mst_state_t st;
		logic [15:0] qcnt;
		logic [1:0] ph;
		logic [3:0] bitn;
		logic [1:0] byten;
		logic rd;
		logic rep;
		logic [7:0] shift;
		logic scl_oe;
		logic sda_oe;
		logic nack;
		logic [6:0] target;
		logic [23:0] txd;
		logic [23:0] rxd;
		logic wreq;
		logic [31:0] rdata;
	} ids_mst_st_t;

	ids_mst_st_t r_ff;
	ids_mst_st_t nxt_r;
	logic tick;
	logic is_tx;
	logic busy;
	logic [7:0] txbyte;
	logic [31:0] wmask;

	assign busy = r_ff.st != MS_IDLE;
	assign tick = r_ff.qcnt == 16'(QTR - 1);
	assign is_tx = !r_ff.rd || r_ff.byten == 2'h0;
	assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	// byte to send: address then control, high, low
	always_comb begin
		case (r_ff.byten)
			2'h0: txbyte = {r_ff.target, r_ff.rd};
			2'h1: txbyte = r_ff.txd[7:0];
			2'h2: txbyte = r_ff.txd[15:8];
			default: txbyte = r_ff.txd[23:16];
		endcase
	end

	// next-state logic: bus slave and bit sequencer
	always_comb begin
		nxt_r = r_ff;
		nxt_r.sda_s1 = link.sda;
		nxt_r.sda_s2 = r_ff.sda_s1;
		// answer one cycle after the request is seen
		if ((avs_read || avs_write) && r_ff.wreq) begin
			nxt_r.wreq = 1'b0;
			case (avs_address)
				REG_TARGET: nxt_r.rdata = {25'h0, r_ff.target};
				REG_TXDATA: nxt_r.rdata = {8'h00, r_ff.txd};
				REG_STATUS: nxt_r.rdata = {30'h0, r_ff.nack, busy};
				REG_RXDATA: nxt_r.rdata = {8'h00, r_ff.rxd};
				default: nxt_r.rdata = 32'h0;
			endcase
		end else if (!r_ff.wreq) begin
			nxt_r.wreq = 1'b1;
			if (avs_write && !busy) begin
				case (avs_address)
					REG_TARGET: nxt_r.target = 7'((avs_writedata & wmask)
						| ({25'h0, r_ff.target} & ~wmask));
					REG_TXDATA: nxt_r.txd = 24'((avs_writedata & wmask)
						| ({8'h00, r_ff.txd} & ~wmask));
					REG_CMD: begin
						if (avs_byteenable[0] && (avs_writedata[CMD_WRITE_BIT]
							|| avs_writedata[CMD_READ_BIT])) begin
							nxt_r.st = MS_START;
							nxt_r.rd = !avs_writedata[CMD_WRITE_BIT];
							nxt_r.rep = avs_writedata[CMD_REPEAT_BIT];
							nxt_r.nack = 1'b0;
							nxt_r.qcnt = 16'h0;
							nxt_r.ph = 2'h0;
						end
					end
					default: begin
					end
				endcase
			end
		end
		if (busy) begin
			nxt_r.qcnt = tick ? 16'h0 : r_ff.qcnt + 16'h1;
		end
		if (busy && tick) begin
			nxt_r.ph = r_ff.ph + 2'h1;
			case (r_ff.st)
				MS_START: begin
					// data falls while clock high, then clock falls
					if (r_ff.ph == 2'h0) begin
						nxt_r.sda_oe = 1'b1;
					end else if (r_ff.ph == 2'h1) begin
						nxt_r.scl_oe = 1'b1;
					end else if (r_ff.ph == 2'h3) begin
						nxt_r.st = MS_BIT;
						nxt_r.bitn = 4'h0;
						nxt_r.byten = 2'h0;
					end
				end
				MS_BIT: begin
					case (r_ff.ph)
						2'h0: begin
							// data changes only with the clock low
							if (r_ff.bitn != BITS_PER_BYTE) begin
								nxt_r.sda_oe = is_tx && !txbyte[~r_ff.bitn[2:0]];
							end else begin
								nxt_r.sda_oe = !is_tx && r_ff.byten != 2'h3;
							end
						end
						2'h1: nxt_r.scl_oe = 1'b0;
						2'h2: begin
							if (r_ff.bitn != BITS_PER_BYTE) begin
								nxt_r.shift = {r_ff.shift[6:0], r_ff.sda_s2};
							end else if (is_tx) begin
								nxt_r.nack = r_ff.sda_s2;
							end else begin
								case (r_ff.byten)
									2'h1: nxt_r.rxd[7:0] = r_ff.shift;
									2'h2: nxt_r.rxd[15:8] = r_ff.shift;
									default: nxt_r.rxd[23:16] = r_ff.shift;
								endcase
							end
						end
						default: begin
							nxt_r.scl_oe = 1'b1;
							if (r_ff.bitn == BITS_PER_BYTE) begin
								nxt_r.bitn = 4'h0;
								nxt_r.byten = r_ff.byten + 2'h1;
								if (r_ff.nack) begin
									nxt_r.st = MS_STOP;
								end else if (r_ff.byten == 2'h3 && r_ff.rep
									&& !r_ff.rd) begin
									// one more high/low pair, same address
									nxt_r.byten = 2'h2;
									nxt_r.rep = 1'b0;
								end else if (r_ff.byten == 2'h3) begin
									nxt_r.st = MS_STOP;
								end
							end else begin
								nxt_r.bitn = r_ff.bitn + 4'h1;
							end
						end
					endcase
				end
				MS_STOP: begin
					// data rises while clock high
					if (r_ff.ph == 2'h0) begin
						nxt_r.sda_oe = 1'b1;
					end else if (r_ff.ph == 2'h1) begin
						nxt_r.scl_oe = 1'b0;
					end else if (r_ff.ph == 2'h2) begin
						nxt_r.sda_oe = 1'b0;
					end else begin
						nxt_r.st = MS_IDLE;
					end
				end
				default: nxt_r.st = MS_IDLE;
			endcase
		end
	end

	// state register
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			r_ff <= '{sda_s1: 1'b1, sda_s2: 1'b1, st: MS_IDLE,
				qcnt: 16'h0, ph: 2'h0, bitn: 4'h0, byten: 2'h0, rd: 1'b0,
				rep: 1'b0, shift: 8'h00, scl_oe: 1'b0, sda_oe: 1'b0,
				nack: 1'b0,
				target: TARGET_RST, txd: 24'h0, rxd: 24'h0, wreq: 1'b1,
				rdata: 32'h0};
		end else begin
			r_ff <= nxt_r;
		end
	end

	// outputs straight from the state register
	assign link.scl_o = 1'b0;
	assign link.sda_m_o = 1'b0;
	assign link.scl_oe = r_ff.scl_oe;
	assign link.sda_m_oe = r_ff.sda_oe;
	assign avs_readdata = r_ff.rdata;
	assign avs_waitrequest = r_ff.wreq;
endmodule : ids_master

// >>> sim/ids_link_assertions.sv
// checker: timing relations on the two-wire link between both ends
`timescale 1ns/1ps
module ids_link_assertions (
	input wire logic clk, // system clock
	input wire logic resetn, // async reset, active low
	input wire logic scl_oe, // master pulls clock low
	input wire logic sda_m_oe, // master pulls data low
	input wire logic sda_s_oe, // device pulls data low
	input wire logic scl, // resolved clock line
	input wire logic sda // resolved data line
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// start and stop events seen on the resolved lines
	sequence s_start;
		scl && $past(scl) && $fell(sda);
	endsequence
	sequence s_stop;
		scl && $past(scl) && $rose(sda);
	endsequence
	// events and framing
	AST_START_BY_MASTER: assert property (
		s_start |-> sda_m_oe && !sda_s_oe)
		else $error("start not made by master");
	AST_STOP_TO_IDLE: assert property (
		s_stop |-> (scl && sda) [*4])
		else $error("bus not idle after stop");
	AST_DEV_QUIET_AFTER_STOP: assert property (
		s_stop |-> !sda_s_oe [*4])
		else $error("device drives after stop");
	// device data only moves while the clock is low
	AST_DEV_SDA_STABLE_HIGH: assert property (
		scl && $past(scl) |-> $stable(sda_s_oe))
		else $error("device data moved with clock high");
	AST_DEV_TURN_DELAY: assert property (
		$fell(scl) |=> $stable(sda_s_oe))
		else $error("device data moved too soon after fall");
	AST_DEV_DRIVE_LOW_PHASE: assert property (
		$rose(sda_s_oe) |-> !scl && !$past(scl, 2))
		else $error("device took data line outside low phase");
	// clock phases made by the master
	AST_SCL_HIGH_WIDTH: assert property (
		$rose(scl) |-> scl [*8])
		else $error("clock high phase too short");
	AST_SCL_LOW_BOUND: assert property (
		$fell(scl) |-> ##[1:40] !scl_oe)
		else $error("clock held low too long");
endmodule : ids_link_assertions

// >>> sim/i2c_dac_slave_sequencer_tb.sv
// testbench: controller and converter joined over the two-wire link
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin mismatches++; \
	$display("wrong value at %0t: %h %h", $time, (a), (e)); end end
module i2c_dac_slave_sequencer_tb
	import ids_pkg::*;
;
	localparam int Q = 8;
	logic clk;
	logic resetn;
	logic address_select_pin;
	logic read_holding;
	logic [4:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [31:0] avs_writedata;
	logic [3:0] avs_byteenable;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [15:0] dac_word_ff;
	logic dac_update_ff;
	logic power_down_ff;
	logic [2:0] shutdown_mode_ff;
	logic [7:0] ctrl_ff;
	logic [31:0] rd;
	logic [31:0] stat;
	int mismatches;
	int checks;
	int upd_n = 0;
	ids_link_if lnk();
	ids_master #(.QTR(Q)) i_ids_master (.clk(clk), .resetn(resetn),
		.link(lnk.master), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
	ids_device i_ids_device (.clk(clk), .resetn(resetn),
		.link(lnk.device), .address_select_pin(address_select_pin),
		.read_holding(read_holding), .dac_word_ff(dac_word_ff),
		.dac_update_ff(dac_update_ff), .power_down_ff(power_down_ff),
		.shutdown_mode_ff(shutdown_mode_ff), .ctrl_ff(ctrl_ff));
	ids_link_assertions i_ids_link_assertions (.clk(clk), .resetn(resetn),
		.scl_oe(lnk.scl_oe), .sda_m_oe(lnk.sda_m_oe),
		.sda_s_oe(lnk.sda_s_oe), .scl(lnk.scl), .sda(lnk.sda));
	// 200 MHz clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// count update pulses
	always @(posedge clk) begin
		if (dac_update_ff === 1'b1) upd_n <= upd_n + 1;
	end
	task close_out;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : close_out
	// one avalon access, held until waitrequest is sampled low
	task av(input logic wr, input logic [4:0] a, input logic [31:0] wd);
		int n;
		@(posedge clk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= wd;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (avs_waitrequest !== 1'b0) begin
			mismatches++;
			close_out();
		end
	endtask : av
	// full link transaction, then status and received bytes
	task xfer(input logic [31:0] tx, input logic [6:0] tgt, input logic r,
		input logic rp = 1'b0);
		int n;
		av(1'b1, REG_TARGET, {25'h0000000, tgt});
		av(1'b1, REG_TXDATA, tx);
		av(1'b1, REG_CMD, {29'h00000000, rp, r, !r});
		n = 0;
		do begin
			av(1'b0, REG_STATUS, 32'h00000000);
			n++;
		end while (rd[STAT_BUSY_BIT] !== 1'b0 && n < 2000);
		if (n >= 2000) begin
			mismatches++;
			close_out();
		end
		stat = rd;
		av(1'b0, REG_RXDATA, 32'h00000000);
	endtask : xfer
	task t_write;
		int u;
		u = upd_n;
		xfer(32'h003CA5FE, {ADDR_PREFIX, 1'b0}, 1'b0);
		`CHK(stat[STAT_NACK_BIT], 1'b0)
		`CHK(ctrl_ff, 8'hFE & ~CTRL_ZERO_MASK)
		`CHK(dac_word_ff, 16'hA53C)
		`CHK(power_down_ff, 1'b0)
		`CHK(upd_n - u, 1)
		$display("test write done");
	endtask : t_write
	task t_power_down;
		int u;
		u = upd_n;
		xfer(32'h0000A001, {ADDR_PREFIX, 1'b0}, 1'b0);
		`CHK(power_down_ff, 1'b1)
		`CHK(shutdown_mode_ff, 3'h5)
		`CHK(dac_word_ff, 16'hA53C)
		`CHK(upd_n - u, 0)
		$display("test power down done");
	endtask : t_power_down
	task t_read(input logic hold);
		read_holding <= hold;
		xfer(32'h00000000, {ADDR_PREFIX, 1'b0}, 1'b1);
		`CHK(stat[STAT_NACK_BIT], 1'b0)
		if (!hold) `CHK(rd[15:0], 16'h3CA5)
		else `CHK(rd[15:0], 16'h00A0)
		`CHK(rd[17:16], {hold, 1'b1})
		`CHK(rd[21:20], 2'h0)
		$display("test read done");
	endtask : t_read
	task t_address;
		int u;
		u = upd_n;
		xfer(32'h00341200, {ADDR_PREFIX, 1'b1}, 1'b0);
		`CHK(stat[STAT_NACK_BIT], 1'b1)
		`CHK(dac_word_ff, 16'hA53C)
		`CHK(upd_n - u, 0)
		address_select_pin <= 1'b1;
		repeat (4) @(posedge clk);
		xfer(32'h00341200, {ADDR_PREFIX, 1'b1}, 1'b0, 1'b1);
		`CHK(stat[STAT_NACK_BIT], 1'b0)
		`CHK(dac_word_ff, 16'h1234)
		`CHK(power_down_ff, 1'b0)
		`CHK(upd_n - u, 2)
		$display("test address done");
	endtask : t_address
	task t_idle;
		av(1'b0, 5'h14, 32'h00000000);
		`CHK(rd, 32'h00000000)
		repeat (200) @(posedge clk);
		`CHK(dac_word_ff, 16'h1234)
		$display("test idle done");
	endtask : t_idle
	// reset, then the scenarios in order
	initial begin
		resetn = 1'b0;
		address_select_pin = 1'b0;
		read_holding = 1'b0;
		avs_address = 5'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h00000000;
		avs_byteenable = 4'hF;
		mismatches = 0;
		checks = 0;
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		repeat (4) @(posedge clk);
		t_write();
		t_power_down();
		t_read(1'b0);
		t_read(1'b1);
		t_address();
		t_idle();
		close_out();
	end
endmodule : i2c_dac_slave_sequencer_tb
